// ===== hw/drive_health_statistics_log.sv
// Health and statistics counters with a word-wide register read port
//
// The strobed register port and the register addresses were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none

// Contract
// RULE_01: Warning byte holds spare, temperature, reliability, read-only, backup flags; top bits zero.
// RULE_02: Report the current temperature as a two-byte Kelvin value.
// RULE_03: Spare capacity percentage starts at 100 and only decreases.
// RULE_04: Spare threshold is fixed at 10; below it sets the spare flag.
// RULE_05: Endurance-used may exceed 100; values above 254 read as 255.
// RULE_06: Endurance-used refreshes once per powered-on hour outside sleep; code also refreshes each low-power minute with minCnt_reg at 59.
// RULE_07: Host read data counted in 512-byte units, reported in thousands, rounded up.
// RULE_08: Host write data counted likewise; write-uncorrectable does not count.
// RULE_09: Separate counters of host read and write commands.
// RULE_10: Busy minutes accumulate while any I/O command is outstanding.
// RULE_11: Count power cycles and power-on hours, excluding low power time; code adds an hour each low-power minute with minCnt_reg at 59.
// RULE_12: Unsafe shutdown counts power loss without prior shutdown notice.
// RULE_13: Count unrecovered integrity errors and error log entries separately.
// RULE_14: Program failures: raw total and normalized remaining from 100.
// RULE_15: Erase failures: raw total and normalized remaining from 100.
// RULE_16: Wear levelling raw min, max, avg; normalized falls from 100 to 0.
// RULE_17: Media wear since workload reset, percentage scaled by 1024.
// RULE_18: Read share since workload reset, integer percent 0 to 100.
// RULE_19: Workload timer counts minutes since last start.
// RULE_20: Throttle: byte 0 percent, bytes 1-4 activation count, byte 5 zero.
// RULE_21: Count link CRC, retry overflow, PLL unlock; normalized always 100.
// RULE_22: Flash and host sectors written divided by 65536.
// RULE_23: Writing one to workload reset clears wear, share and timer; zero does nothing.
// RULE_24: Wide counters saturate instead of wrapping.
module drive_health_statistics_log #(
    parameter longint MINUTE_CYCLES = health_log_pkg::MINUTE_CYC,
    parameter int CNT_W = 32
) (
    input wire logic sys_clk,
    input wire logic rst,
    input wire logic [7:0] regAddr,
    input wire logic [31:0] regWrData,
    input wire logic regWrStb,
    input wire logic regRdStb,
    output logic [31:0] regRdData,
    input wire logic [15:0] tempKelvin,
    input wire logic overTemp,
    input wire logic reliabDegraded,
    input wire logic mediaReadOnly,
    input wire logic backupFail,
    input wire logic [7:0] spareLeft,
    input wire logic [7:0] usedEstimate,
    input wire logic lowPower,
    input wire logic powerUp,
    input wire logic shutdownNotice,
    input wire logic readDone,
    input wire logic writeDone,
    input wire logic writeUncorr,
    input wire logic [3:0] blockUnits,
    input wire logic ioOutstanding,
    input wire logic mediaError,
    input wire logic errLogEntry,
    input wire logic programFail,
    input wire logic eraseFail,
    input wire logic [7:0] programFailNorm,
    input wire logic [7:0] eraseFailNorm,
    input wire logic [15:0] eraseMin,
    input wire logic [15:0] eraseMax,
    input wire logic [15:0] eraseAvg,
    input wire logic [7:0] wearNorm,
    input wire logic e2eCorrected,
    input wire logic linkCrcError,
    input wire logic retryOverflow,
    input wire logic pllUnlock,
    input wire logic [31:0] wearCycleUnits,
    input wire logic [7:0] throttlePct,
    input wire logic throttleStart,
    input wire logic [31:0] throttleCountSaved,
    input wire logic flashSector,
    output logic spareWarning
);

    // ---------------------------------------------------------------
    // Saturating increment helper
    // ---------------------------------------------------------------
    function automatic logic [CNT_W-1:0] satInc(input logic [CNT_W-1:0] v, input logic en);
        satInc = (en && (v != {CNT_W{1'b1}})) ? v + 1'b1 : v;
    endfunction

    // ---------------------------------------------------------------
    // Time base: minute tick, hour tick
    // ---------------------------------------------------------------
    logic [31:0] cycCnt_reg;
    logic [5:0] minCnt_reg;
    wire minuteTick = (cycCnt_reg == 32'(MINUTE_CYCLES - 1));
    wire hourTick = minuteTick && (minCnt_reg == 6'(health_log_pkg::HOUR_MIN - 1));

    // Counts system cycles and awake minutes
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            cycCnt_reg <= 32'h0;
            minCnt_reg <= 6'h0;
        end else begin
            cycCnt_reg <= minuteTick ? 32'h0 : cycCnt_reg + 32'h1;
            if (minuteTick && !lowPower) begin
                minCnt_reg <= hourTick ? 6'h0 : minCnt_reg + 6'h1;
            end
        end
    end

    // ---------------------------------------------------------------
    // Register write decode
    // ---------------------------------------------------------------
    // RULE_23: workload reset on one
    wire wlReset = regWrStb && (regAddr == health_log_pkg::IDX_WL_RESET) && regWrData[0];
    wire wrCount = writeDone && !writeUncorr;

    // ---------------------------------------------------------------
    // Counter state
    // ---------------------------------------------------------------
    logic [7:0] spare_reg, used_reg;
    logic [9:0] rdFrac_reg, wrFrac_reg;
    logic [CNT_W-1:0] unitsRd_reg, unitsWr_reg, cmdRd_reg, cmdWr_reg, busyMin_reg;
    logic [CNT_W-1:0] pwrCyc_reg, pwrHrs_reg, unsafe_reg, mediaErr_reg, errLog_reg;
    logic [CNT_W-1:0] progFail_reg, eraseFail_reg, e2e_reg, linkCrc_reg;
    logic [CNT_W-1:0] retryOvf_reg, pllUnl_reg, wlTimer_reg, throtCnt_reg;
    logic [CNT_W-1:0] flashVol_reg, hostVol_reg, wlReads_reg, wlOps_reg;
    logic [CNT_W-1:0] wearBase_reg;
    logic [15:0] flashSect_reg, hostSect_reg;
    logic armed_reg, shutdownSeen_reg, throtLoaded_reg;

    // Thousand-unit accumulators: first unit bumps count (round up)
    // RULE_07: read data units
    wire [9:0] rdSum = rdFrac_reg + {6'h0, blockUnits};
    wire rdWrap = readDone && (rdFrac_reg == 10'h0 || rdSum > health_log_pkg::UNITS_PER_COUNT);
    // RULE_08: write data units
    wire [9:0] wrSum = wrFrac_reg + {6'h0, blockUnits};
    wire wrWrap = wrCount && (wrFrac_reg == 10'h0 || wrSum > health_log_pkg::UNITS_PER_COUNT);

    // Fraction trackers for the thousand-unit counters
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            rdFrac_reg <= 10'h0;
            wrFrac_reg <= 10'h0;
        end else begin
            if (readDone) begin
                rdFrac_reg <= (rdSum >= health_log_pkg::UNITS_PER_COUNT) ?
                    rdSum - health_log_pkg::UNITS_PER_COUNT : rdSum;
            end
            if (wrCount) begin
                wrFrac_reg <= (wrSum >= health_log_pkg::UNITS_PER_COUNT) ?
                    wrSum - health_log_pkg::UNITS_PER_COUNT : wrSum;
            end
        end
    end

    // Spare and endurance estimates
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            spare_reg <= health_log_pkg::PCT_FULL;
            used_reg <= 8'h0;
        end else begin
            // RULE_03: spare only decreases
            if (spareLeft < spare_reg) begin
                spare_reg <= spareLeft;
            end
            // RULE_06: refresh on hourTick, hourly while awake and at each low-power minute with minCnt_reg at 59
            // RULE_05: saturate above 254
            if (hourTick) begin
                used_reg <= (usedEstimate > health_log_pkg::USED_CAP) ?
                    health_log_pkg::USED_SAT : usedEstimate;
            end
        end
    end

    // Power-on bookkeeping and shutdown notice tracking
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            armed_reg <= 1'b0;
            shutdownSeen_reg <= 1'b0;
        end else begin
            if (powerUp) begin
                armed_reg <= 1'b1;
            end
            // A notice in the power-up cycle still counts as seen
            shutdownSeen_reg <= shutdownNotice || (shutdownSeen_reg && !powerUp);
        end
    end

    // Host traffic, power and error counters
    // RULE_24: all wide counters saturate
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            unitsRd_reg <= '0;
            unitsWr_reg <= '0;
            cmdRd_reg <= '0;
            cmdWr_reg <= '0;
            busyMin_reg <= '0;
            pwrCyc_reg <= '0;
            pwrHrs_reg <= '0;
            unsafe_reg <= '0;
            mediaErr_reg <= '0;
            errLog_reg <= '0;
        end else begin
            unitsRd_reg <= satInc(unitsRd_reg, rdWrap);
            unitsWr_reg <= satInc(unitsWr_reg, wrWrap);
            // RULE_09: command counters
            cmdRd_reg <= satInc(cmdRd_reg, readDone);
            cmdWr_reg <= satInc(cmdWr_reg, writeDone);
            // RULE_10: busy minute counted when I/O is outstanding at the minute tick
            if (ioOutstanding && minuteTick) begin
                busyMin_reg <= satInc(busyMin_reg, 1'b1);
            end
            // RULE_11: power cycles and hours, counting awake hours and each low-power minute with minCnt_reg at 59
            pwrCyc_reg <= satInc(pwrCyc_reg, powerUp);
            pwrHrs_reg <= satInc(pwrHrs_reg, hourTick);
            // RULE_12: unsafe loss of power
            unsafe_reg <= satInc(unsafe_reg, powerUp && armed_reg && !shutdownSeen_reg);
            // RULE_13: integrity errors and log entries
            mediaErr_reg <= satInc(mediaErr_reg, mediaError);
            errLog_reg <= satInc(errLog_reg, errLogEntry);
        end
    end

    // Vendor attribute counters
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            progFail_reg <= '0;
            eraseFail_reg <= '0;
            e2e_reg <= '0;
            linkCrc_reg <= '0;
            retryOvf_reg <= '0;
            pllUnl_reg <= '0;
            throtCnt_reg <= '0;
            throtLoaded_reg <= 1'b0;
            flashSect_reg <= 16'h0;
            hostSect_reg <= 16'h0;
            flashVol_reg <= '0;
            hostVol_reg <= '0;
        end else begin
            // RULE_14: program failures
            progFail_reg <= satInc(progFail_reg, programFail);
            // RULE_15: erase failures
            eraseFail_reg <= satInc(eraseFail_reg, eraseFail);
            e2e_reg <= satInc(e2e_reg, e2eCorrected);
            // RULE_21: link fault counters
            linkCrc_reg <= satInc(linkCrc_reg, linkCrcError);
            retryOvf_reg <= satInc(retryOvf_reg, retryOverflow);
            pllUnl_reg <= satInc(pllUnl_reg, pllUnlock);
            // RULE_20: activation count restored then counted
            if (!throtLoaded_reg) begin
                throtCnt_reg <= throttleCountSaved[CNT_W-1:0];
                throtLoaded_reg <= 1'b1;
            end else begin
                throtCnt_reg <= satInc(throtCnt_reg, throttleStart);
            end
            // RULE_22: one count per 65536 sectors
            if (flashSector) begin
                flashSect_reg <= flashSect_reg + 16'h1;
                flashVol_reg <= satInc(flashVol_reg,
                    flashSect_reg == health_log_pkg::SECT_PER_VOL);
            end
            if (wrCount) begin
                hostSect_reg <= hostSect_reg + 16'h1;
                hostVol_reg <= satInc(hostVol_reg,
                    hostSect_reg == health_log_pkg::SECT_PER_VOL);
            end
        end
    end

    // Timed workload counters
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            wlTimer_reg <= '0;
            wlReads_reg <= '0;
            wlOps_reg <= '0;
            wearBase_reg <= '0;
        end else if (wlReset) begin
            // RULE_23: clear the three workload counters
            wlTimer_reg <= '0;
            wlReads_reg <= '0;
            wlOps_reg <= '0;
            wearBase_reg <= wearCycleUnits[CNT_W-1:0];
        end else begin
            // RULE_19: minute timer
            wlTimer_reg <= satInc(wlTimer_reg, minuteTick);
            wlReads_reg <= satInc(wlReads_reg, readDone);
            wlOps_reg <= satInc(wlOps_reg, readDone || writeDone);
        end
    end

    // ---------------------------------------------------------------
    // Derived values
    // ---------------------------------------------------------------
    // RULE_04: spare below fixed threshold
    assign spareWarning = spare_reg < health_log_pkg::SPARE_THRESH;
    // RULE_01: warning byte, bits 7:5 zero
    wire [7:0] warnByte = {3'b000, backupFail, mediaReadOnly, reliabDegraded, overTemp,
        spareWarning};
    // RULE_17: wear scaled by 1024 since reset
    wire [CNT_W-1:0] mediaUse = wearCycleUnits[CNT_W-1:0] - wearBase_reg;
    // RULE_18: integer read percentage
    wire [CNT_W+6:0] readScaled = {7'h0, wlReads_reg} * (CNT_W+7)'(100);
    wire [CNT_W+6:0] readShareW = (wlOps_reg == '0) ? '0 :
        readScaled / {7'h0, wlOps_reg};
    wire [7:0] readShare = readShareW[7:0];
    wire [7:0] pctFull = health_log_pkg::PCT_FULL;

    // ---------------------------------------------------------------
    // Read multiplexer
    // ---------------------------------------------------------------
    logic [31:0] rdMux;
    always_comb begin
        case (regAddr)
            health_log_pkg::IDX_WARN: rdMux = {24'h0, warnByte};
            // RULE_02: Kelvin temperature
            health_log_pkg::IDX_TEMP: rdMux = {16'h0, tempKelvin};
            health_log_pkg::IDX_SPARE: rdMux = {16'h0, health_log_pkg::SPARE_THRESH, spare_reg};
            health_log_pkg::IDX_USED: rdMux = {24'h0, used_reg};
            health_log_pkg::IDX_UNITS_RD: rdMux = 32'(unitsRd_reg);
            health_log_pkg::IDX_UNITS_WR: rdMux = 32'(unitsWr_reg);
            health_log_pkg::IDX_CMD_RD: rdMux = 32'(cmdRd_reg);
            health_log_pkg::IDX_CMD_WR: rdMux = 32'(cmdWr_reg);
            health_log_pkg::IDX_BUSY_MIN: rdMux = 32'(busyMin_reg);
            health_log_pkg::IDX_PWR_CYC: rdMux = 32'(pwrCyc_reg);
            health_log_pkg::IDX_PWR_HRS: rdMux = 32'(pwrHrs_reg);
            health_log_pkg::IDX_UNSAFE: rdMux = 32'(unsafe_reg);
            health_log_pkg::IDX_MEDIA_ERR: rdMux = 32'(mediaErr_reg);
            health_log_pkg::IDX_ERRLOG: rdMux = 32'(errLog_reg);
            health_log_pkg::IDX_PROG_FAIL: rdMux = {programFailNorm, 24'(progFail_reg)};
            health_log_pkg::IDX_ERASE_FAIL: rdMux = {eraseFailNorm, 24'(eraseFail_reg)};
            // RULE_16: wear levelling fields
            health_log_pkg::IDX_WEAR_MINMAX: rdMux = {eraseMax, eraseMin};
            health_log_pkg::IDX_WEAR_AVG: rdMux = {wearNorm, 8'h0, eraseAvg};
            health_log_pkg::IDX_E2E: rdMux = {pctFull, 24'(e2e_reg)};
            health_log_pkg::IDX_LINK_CRC: rdMux = {pctFull, 24'(linkCrc_reg)};
            health_log_pkg::IDX_MEDIA_USE: rdMux = 32'(mediaUse);
            health_log_pkg::IDX_READ_SHARE: rdMux = {pctFull, 16'h0, readShare};
            health_log_pkg::IDX_WL_TIMER: rdMux = {pctFull, 24'(wlTimer_reg)};
            health_log_pkg::IDX_THROTTLE: rdMux = {pctFull, 16'h0, throttlePct};
            health_log_pkg::IDX_THROT_CNT: rdMux = 32'(throtCnt_reg);
            health_log_pkg::IDX_RETRY_OVF: rdMux = {pctFull, 24'(retryOvf_reg)};
            health_log_pkg::IDX_PLL_UNLOCK: rdMux = {pctFull, 24'(pllUnl_reg)};
            health_log_pkg::IDX_FLASH_VOL: rdMux = 32'(flashVol_reg);
            health_log_pkg::IDX_HOST_VOL: rdMux = 32'(hostVol_reg);
            default: rdMux = 32'h0;
        endcase
    end

    // Read data registered one cycle after the strobe
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            regRdData <= 32'h0;
        end else begin
            regRdData <= regRdStb ? rdMux : 32'h0;
        end
    end

    // ---------------------------------------------------------------
    // Checks
    // ---------------------------------------------------------------
    warn_top_zero_a: assert property (@(posedge sys_clk) disable iff (rst) // RULE_01
        warnByte[7:5] == 3'b000) else $error("warning top bits set");
    spare_mono_a: assert property (@(posedge sys_clk) disable iff (rst) // RULE_03
        spare_reg <= $past(spare_reg)) else $error("spare increased");
    spare_flag_a: assert property (@(posedge sys_clk) disable iff (rst) // RULE_04
        spareWarning == (spare_reg < 8'h0A)) else $error("spare flag wrong");
    used_sat_a: assert property (@(posedge sys_clk) disable iff (rst) // RULE_05
        hourTick && usedEstimate > 8'hFE |=> used_reg == 8'hFF) else $error("used not 255");
    used_hold_a: assert property (@(posedge sys_clk) disable iff (rst) // RULE_06
        !hourTick |=> $stable(used_reg)) else $error("used changed off hour");
    cmd_rd_a: assert property (@(posedge sys_clk) disable iff (rst) // RULE_09
        readDone && cmdRd_reg != '1 |=> cmdRd_reg == $past(cmdRd_reg) + 1'b1)
        else $error("read command not counted");
    uncorr_a: assert property (@(posedge sys_clk) disable iff (rst) // RULE_08
        writeUncorr && !readDone |=> $stable(unitsWr_reg)) else $error("uncorr counted");
    media_sat_a: assert property (@(posedge sys_clk) disable iff (rst) // RULE_24
        mediaErr_reg == '1 |=> mediaErr_reg == '1) else $error("counter wrapped");
    wl_clear_a: assert property (@(posedge sys_clk) disable iff (rst) // RULE_23
        wlReset |=> wlTimer_reg == '0 && wlOps_reg == '0) else $error("workload not cleared");
    share_range_a: assert property (@(posedge sys_clk) disable iff (rst) // RULE_18
        readShare <= 8'h64) else $error("read share above 100");
    rd_lat_a: assert property (@(posedge sys_clk) disable iff (rst) // RULE_02
        regRdStb && regAddr == 8'h01 |=> regRdData == {16'h0, $past(tempKelvin)})
        else $error("temperature read wrong");

endmodule

`default_nettype wire

// ===== hw/health_log_pkg.sv
// Constants for the drive health and statistics log block
package health_log_pkg;
    // ---------------------------------------------------------------
    // Register word indices (32-bit words, byte address = 4 * index)
    // ---------------------------------------------------------------
    localparam logic [7:0] IDX_WARN = 8'h00;
    localparam logic [7:0] IDX_TEMP = 8'h01;
    localparam logic [7:0] IDX_SPARE = 8'h02;
    localparam logic [7:0] IDX_USED = 8'h03;
    localparam logic [7:0] IDX_UNITS_RD = 8'h04;
    localparam logic [7:0] IDX_UNITS_WR = 8'h05;
    localparam logic [7:0] IDX_CMD_RD = 8'h06;
    localparam logic [7:0] IDX_CMD_WR = 8'h07;
    localparam logic [7:0] IDX_BUSY_MIN = 8'h08;
    localparam logic [7:0] IDX_PWR_CYC = 8'h09;
    localparam logic [7:0] IDX_PWR_HRS = 8'h0A;
    localparam logic [7:0] IDX_UNSAFE = 8'h0B;
    localparam logic [7:0] IDX_MEDIA_ERR = 8'h0C;
    localparam logic [7:0] IDX_ERRLOG = 8'h0D;
    localparam logic [7:0] IDX_PROG_FAIL = 8'h0E;
    localparam logic [7:0] IDX_ERASE_FAIL = 8'h0F;
    localparam logic [7:0] IDX_WEAR_MINMAX = 8'h10;
    localparam logic [7:0] IDX_WEAR_AVG = 8'h11;
    localparam logic [7:0] IDX_E2E = 8'h12;
    localparam logic [7:0] IDX_LINK_CRC = 8'h13;
    localparam logic [7:0] IDX_MEDIA_USE = 8'h14;
    localparam logic [7:0] IDX_READ_SHARE = 8'h15;
    localparam logic [7:0] IDX_WL_TIMER = 8'h16;
    localparam logic [7:0] IDX_THROTTLE = 8'h17;
    localparam logic [7:0] IDX_THROT_CNT = 8'h18;
    localparam logic [7:0] IDX_RETRY_OVF = 8'h19;
    localparam logic [7:0] IDX_PLL_UNLOCK = 8'h1A;
    localparam logic [7:0] IDX_FLASH_VOL = 8'h1B;
    localparam logic [7:0] IDX_HOST_VOL = 8'h1C;
    localparam logic [7:0] IDX_WL_RESET = 8'h1D;
    // ---------------------------------------------------------------
    // Field positions and fixed values
    // ---------------------------------------------------------------
    localparam int WARN_SPARE = 0;
    localparam int WARN_TEMP = 1;
    localparam int WARN_RELIAB = 2;
    localparam int WARN_RDONLY = 3;
    localparam int WARN_BACKUP = 4;
    localparam logic [7:0] PCT_FULL = 8'h64;
    localparam logic [7:0] SPARE_THRESH = 8'h0A;
    localparam logic [7:0] USED_CAP = 8'hFE;
    localparam logic [7:0] USED_SAT = 8'hFF;
    localparam logic [9:0] UNITS_PER_COUNT = 10'h3E8;
    localparam logic [15:0] SECT_PER_VOL = 16'hFFFF;
    localparam logic [31:0] CNT_MAX = 32'hFFFFFFFF;
    // ---------------------------------------------------------------
    // Timing: clock rate and tick periods
    // ---------------------------------------------------------------
    localparam longint CLK_HZ = 10000000;
    localparam longint MINUTE_S = 60;
    localparam longint MINUTE_CYC = CLK_HZ * MINUTE_S;
    localparam int HOUR_MIN = 60;
endpackage

// ===== test/host_log_master.sv
// Host-side register master that reads log words and writes the reset setting
`timescale 1ns/1ps
`default_nettype none
module host_log_master (
    input wire logic sys_clk,
    input wire logic [31:0] regRdData,
    output logic [7:0] regAddr,
    output logic [31:0] regWrData,
    output logic regWrStb,
    output logic regRdStb
);
    // ----------------
    // Bus cycles
    // ----------------
    // Idle bus at time zero
    initial begin
        regAddr = 8'h00;
        regWrData = 32'h0;
        regWrStb = 1'b0;
        regRdStb = 1'b0;
    end
    // One-cycle read, data taken in the cycle after the strobe
    task automatic rd(input logic [7:0] a, output logic [31:0] v);
        @(posedge sys_clk);
        regAddr <= a;
        regRdStb <= 1'b1;
        @(posedge sys_clk);
        regRdStb <= 1'b0;
        regAddr <= ~a; // Released address keeps moving
        #1 v = regRdData;
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] v);
        @(posedge sys_clk);
        regAddr <= a;
        regWrData <= v;
        regWrStb <= 1'b1;
        @(posedge sys_clk);
        regWrStb <= 1'b0;
        regWrData <= ~v;
    endtask
endmodule
`default_nettype wire

// ===== test/testbench.sv
// Self-checking bench for the health and statistics log block
`timescale 1ns/1ps
`default_nettype none
module testbench;
    // ----------------
    // Stimulus, bus and checks
    // ----------------
    localparam logic [31:0] M = 32'hFFFFFFFF;
    logic sys_clk = 1'b0;
    logic rst = 1'b1;
    logic [13:0] ev = 14'h0;
    logic [15:0] temp = 16'h012C, emin = 16'h0011, emax = 16'h0022, eavg = 16'h0033;
    logic [7:0] spare = 8'h64, pct = 8'h2A, nrm = 8'h64;
    logic [3:0] bu = 4'h1;
    logic ovt = 1'b0, bak = 1'b0, unc = 1'b0, io = 1'b0;
    logic [31:0] sav = 32'h5, wcu = 32'h400, d, regWrData, regRdData;
    logic [7:0] regAddr;
    logic regWrStb, regRdStb, spareWarning;
    int miscompares = 0, num_checks = 0, cyc = 0;
    host_log_master host (.sys_clk(sys_clk), .regRdData(regRdData), .regAddr(regAddr),
        .regWrData(regWrData), .regWrStb(regWrStb), .regRdStb(regRdStb));
    drive_health_statistics_log #(.MINUTE_CYCLES(10)) dut (.sys_clk(sys_clk), .rst(rst),
        .regAddr(regAddr), .regWrData(regWrData), .regWrStb(regWrStb), .regRdStb(regRdStb),
        .regRdData(regRdData), .tempKelvin(temp), .overTemp(ovt), .reliabDegraded(io),
        .mediaReadOnly(unc), .backupFail(bak), .spareLeft(spare), .usedEstimate(8'hFF),
        .lowPower(1'b0), .powerUp(ev[0]), .shutdownNotice(ev[1]), .readDone(ev[2]),
        .writeDone(ev[3]), .writeUncorr(unc), .blockUnits(bu), .ioOutstanding(io),
        .mediaError(ev[4]), .errLogEntry(ev[5]), .programFail(ev[6]), .eraseFail(ev[7]),
        .programFailNorm(nrm), .eraseFailNorm(nrm), .eraseMin(emin), .eraseMax(emax),
        .eraseAvg(eavg), .wearNorm(nrm), .e2eCorrected(ev[8]), .linkCrcError(ev[9]),
        .retryOverflow(ev[10]), .pllUnlock(ev[11]), .wearCycleUnits(wcu),
        .throttlePct(pct), .throttleStart(ev[12]), .throttleCountSaved(sav),
        .flashSector(ev[13]), .spareWarning(spareWarning));
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        num_checks++;
        if (seen !== exp) begin
            miscompares++;
            $display("Error at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic rc(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
        host.rd(a, d);
        chk(d & m, e);
    endtask
    task automatic pulse(input int i, input int n);
        repeat (n) begin
            @(posedge sys_clk);
            ev[i] <= 1'b1;
            @(posedge sys_clk);
            ev[i] <= 1'b0;
        end
    endtask
    task automatic t_warn;
        spare <= 8'h09;
        ovt <= 1'b1;
        bak <= 1'b1;
        repeat (2) @(posedge sys_clk);
        chk(spareWarning, 1'b1);
        rc(health_log_pkg::IDX_WARN, M, 32'h13);
        rc(health_log_pkg::IDX_TEMP, M, {16'h0, temp});
        spare <= 8'h32;
        rc(health_log_pkg::IDX_SPARE, M, 32'h0A09);
        rc(health_log_pkg::IDX_WEAR_MINMAX, M, {emax, emin});
        rc(health_log_pkg::IDX_WEAR_AVG, M, {nrm, 8'h0, eavg});
        rc(8'h40, M, 32'h0);
        $display("warning test done");
    endtask
    task automatic t_units;
        pulse(2, 1);
        bu <= 4'hF;
        pulse(2, 66);
        bu <= 4'h9;
        pulse(2, 1);
        rc(health_log_pkg::IDX_UNITS_RD, M, 32'h1);
        bu <= 4'h1;
        pulse(2, 1);
        rc(health_log_pkg::IDX_UNITS_RD, M, 32'h2);
        rc(health_log_pkg::IDX_CMD_RD, M, 32'h45);
        unc <= 1'b1;
        pulse(3, 1);
        rc(health_log_pkg::IDX_UNITS_WR, M, 32'h0);
        unc <= 1'b0;
        pulse(3, 1);
        rc(health_log_pkg::IDX_UNITS_WR, M, 32'h1);
        $display("data unit test done");
    endtask
    task automatic t_events;
        logic [7:0] ix [8] = '{health_log_pkg::IDX_MEDIA_ERR, health_log_pkg::IDX_ERRLOG,
            health_log_pkg::IDX_PROG_FAIL, health_log_pkg::IDX_ERASE_FAIL,
            health_log_pkg::IDX_E2E, health_log_pkg::IDX_LINK_CRC,
            health_log_pkg::IDX_RETRY_OVF, health_log_pkg::IDX_PLL_UNLOCK};
        for (int i = 0; i < 8; i++) begin
            pulse(i + 4, 2);
            rc(ix[i], 32'h00FFFFFF, 32'h2);
        end
        pulse(0, 1);
        pulse(1, 1);
        pulse(0, 2);
        rc(health_log_pkg::IDX_PWR_CYC, M, 32'h3);
        rc(health_log_pkg::IDX_UNSAFE, M, 32'h1);
        pulse(12, 1);
        rc(health_log_pkg::IDX_THROT_CNT, M, 32'h6);
        rc(health_log_pkg::IDX_THROTTLE, 32'hFF, {24'h0, pct});
        $display("event counter test done");
    endtask
    task automatic t_workload;
        io <= 1'b1;
        repeat (35) @(posedge sys_clk);
        io <= 1'b0;
        host.rd(health_log_pkg::IDX_BUSY_MIN, d);
        chk((d == 32'h3) || (d == 32'h4), 1'b1);
        rc(health_log_pkg::IDX_WL_TIMER, 32'h00FFFFFF, 32'h1B);
        host.wr(health_log_pkg::IDX_WL_RESET, 32'h0);
        rc(health_log_pkg::IDX_WL_TIMER, 32'h00FFFFFF, 32'h1B);
        host.wr(health_log_pkg::IDX_WL_RESET, 32'h1);
        rc(health_log_pkg::IDX_WL_TIMER, 32'h00FFFFFE, 32'h0);
        rc(health_log_pkg::IDX_READ_SHARE, M, 32'h64000000);
        rc(health_log_pkg::IDX_MEDIA_USE, M, 32'h0);
        wcu <= 32'h480;
        rc(health_log_pkg::IDX_MEDIA_USE, M, 32'h80);
        pulse(2, 1);
        pulse(3, 1);
        rc(health_log_pkg::IDX_READ_SHARE, M, 32'h64000032);
        repeat (320) @(posedge sys_clk);
        rc(health_log_pkg::IDX_USED, M, 32'hFF);
        rc(health_log_pkg::IDX_PWR_HRS, M, 32'h1);
        $display("workload test done");
    endtask
    task automatic end_of_test;
        $display("checks %0d mismatches %0d", num_checks, miscompares);
        if (miscompares == 0 && num_checks > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask
    // Clock at 10 MHz
    initial begin
        forever #50 sys_clk = ~sys_clk;
    end
    // Cycle ceiling against hangs
    always @(posedge sys_clk) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            miscompares++;
            end_of_test;
        end
    end
    // Reset, then the scenarios in turn
    initial begin
        repeat (5) @(posedge sys_clk);
        rst <= 1'b0;
        t_warn;
        t_units;
        t_events;
        t_workload;
        end_of_test;
    end
endmodule
`default_nettype wire
